// ---- inc/stat_irq_pkg.sv ----
// Constants and carrier types for the latched status and interrupt logic
package stat_irq_pkg;
    localparam int          NUM_FRAMERS   = 4;
    localparam int          NUM_REGS      = 9;
    localparam int          NUM_LATCHED   = 5;
    localparam logic [7:0]  SUMMARY_BASE  = 8'ha0;
    localparam logic [3:0]  REG_STATUS_ONE  = 4'h0;
    localparam logic [3:0]  REG_STATUS_TWO  = 4'h1;
    localparam logic [3:0]  REG_RX_INFO_ONE = 4'h2;
    localparam logic [3:0]  REG_LINK_STATUS = 4'h5;
    localparam logic [7:0]  ALARM_BITS    = 8'h0f;
    localparam logic [7:0]  BYTE_ZERO     = 8'h00;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [1:0] framer;
        logic [3:0] reg_sel;
        logic [7:0] wdata;
    } host_req_t;

    typedef struct packed {
        logic [7:0] irq_mask_one;
        logic [7:0] irq_mask_two;
        logic [7:0] link_ctrl_irq_mask;
    } irq_masks_t;
endpackage

// ---- rtl/stat_irq_ctrl.sv ----
// Per-framer latched status registers, interrupt masking and summary
`timescale 1ns/100ps
// Behaviour
// - Nine status-type registers per framer
// - Event or alarm sets its status bit
// - Bits of registers 0 to 4 latch until a mask-one write
// - Read leaves the bit set; only mask-one writes clear it
// - Persisting alarms stay set after read
// - Mask one refreshes view and clears latch
// - Mask zero holds view, latch kept
// - Per-bit mask gates interrupt sources
// - Alarm bits interrupt on every change
// - Alarm interrupt released when bit read
// - Event interrupt on occurrence, released on read
// - Summary: bit 2n status, 2n+1 link
// - Summary answers whole upper address range
module stat_irq_ctrl
    import stat_irq_pkg::*;
(
    // Clock and reset
    input  wire logic                              ref_clk,
    input  wire logic                              rst,
    // Host port
    input  wire host_req_t                         host_req,
    input  wire logic [7:0]                        host_addr,
    output logic [7:0]                             host_rdata,
    // Masks per framer
    input  wire irq_masks_t [NUM_FRAMERS-1:0]      masks,
    // Asynchronous status conditions, framer*register*bit
    input  wire logic [NUM_FRAMERS*NUM_REGS*8-1:0] status_in,
    // Interrupt
    output logic                                   int_n
);
    localparam int NBITS = NUM_FRAMERS * NUM_REGS * 8;

    logic [NBITS-1:0] sync1_r;
    logic [NBITS-1:0] sync2_r;
    logic [NBITS-1:0] view;
    logic [NBITS-1:0] req;
    logic [7:0]       summary_r;
    logic [7:0]       summary_nxt;
    logic [7:0]       rdata_r;
    logic [7:0]       rdata_nxt;
    logic             int_n_r;
    logic             summary_hit;
    logic             any_req;

    // Two-flop synchroniser for the asynchronous conditions
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= status_in;
            sync2_r <= sync1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // One cell per bit of every register of every framer. The write and the
    // read strobes are decoded here so each cell sees only its own register;
    // the summary range is kept out so a write there can never clear a latch.
    genvar f, r, b;
    generate
        for (f = 0; f < NUM_FRAMERS; f++) begin : g_fr
            for (r = 0; r < NUM_REGS; r++) begin : g_reg
                for (b = 0; b < 8; b++) begin : g_bit
                    localparam int IDX = (f*NUM_REGS + r)*8 + b;
                    logic sel;
                    assign sel = (host_req.framer == 2'(f)) && (host_req.reg_sel == 4'(r))
                                 && (host_addr < SUMMARY_BASE);
                    status_bit_cell u_cell (
                        .ref_clk  (ref_clk),
                        .rst      (rst),
                        .cond     (sync2_r[IDX]),
                        .is_alarm ((r == 0) && ALARM_BITS[b]),
                        .latching (r < NUM_LATCHED),
                        .mask_wr  (sel & host_req.wr),
                        .mask_bit (host_req.wdata[b]),
                        .rd_stb   (sel & host_req.rd),
                        .read_bit (view[IDX]),
                        .irq_req  (req[IDX])
                    );
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Only the two status registers and the first link register may request.
    // The remaining link registers hold level information and stay silent.
    always_comb begin
        summary_nxt = BYTE_ZERO;
        for (int i = 0; i < NUM_FRAMERS; i++) begin
            summary_nxt[2*i] =
                |(req[(i*NUM_REGS+REG_STATUS_ONE)*8 +: 8] & masks[i].irq_mask_one) |
                |(req[(i*NUM_REGS+REG_STATUS_TWO)*8 +: 8] & masks[i].irq_mask_two);
            summary_nxt[2*i+1] =
                |(req[(i*NUM_REGS+REG_LINK_STATUS)*8 +: 8] & masks[i].link_ctrl_irq_mask);
        end
    end

    assign summary_hit = host_addr >= SUMMARY_BASE;
    assign any_req     = |summary_nxt;
    assign rdata_nxt   = summary_hit ? summary_r
                       : view[(32'(host_req.framer)*NUM_REGS + 32'(host_req.reg_sel))*8 +: 8];

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            summary_r <= BYTE_ZERO;
            rdata_r   <= BYTE_ZERO;
            int_n_r   <= 1'b1;
        end else begin
            summary_r <= summary_nxt;
            int_n_r   <= ~any_req;
            if (host_req.rd)
                rdata_r <= rdata_nxt;
        end
    end

    // Pin and summary come from the same term in the same cycle, so a host
    // that polls the summary after seeing the pin low always finds a flag.
    assign host_rdata = rdata_r;
    assign int_n      = int_n_r;

    ////////////////////////////////////////////////////////////////////////
    // Interrupt pin checks
    a_int_follows_req: assert property (@(posedge ref_clk) disable iff (rst)
        any_req |=> !int_n) else $error("interrupt not asserted");
    a_int_idle_high: assert property (@(posedge ref_clk) disable iff (rst)
        !any_req |=> int_n) else $error("interrupt stuck low");
    a_int_matches_sum: assert property (@(posedge ref_clk) disable iff (rst)
        int_n == (summary_r == BYTE_ZERO)) else $error("interrupt and summary disagree");
    // Reset must leave the pin released whatever the conditions are doing
    a_reset_int_high: assert property (@(posedge ref_clk)
        rst |=> int_n) else $error("interrupt low after reset");

    ////////////////////////////////////////////////////////////////////////
    // Host read and write path checks
    a_summary_read: assert property (@(posedge ref_clk) disable iff (rst)
        host_req.rd && summary_hit |=> host_rdata == $past(summary_r)) else $error("summary read wrong");
    // Read data is held between reads so a slow host may sample it late
    a_rdata_holds: assert property (@(posedge ref_clk) disable iff (rst)
        !host_req.rd |=> $stable(host_rdata)) else $error("read data changed without a read");
    // A write into the summary range must not touch any status register
    a_sum_wr_ignored: assert property (@(posedge ref_clk) disable iff (rst)
        host_req.wr && summary_hit |=> $stable(view)) else $error("summary write reached a register");

    ////////////////////////////////////////////////////////////////////////
    // Per-framer summary checks against the masks and the cell requests
    genvar g;
    generate
        for (g = 0; g < NUM_FRAMERS; g++) begin : g_sum_chk
            logic stat_off;
            logic link_off;
            logic one_hit;
            logic link_hit;
            // A framer with every source masked must never raise its flags
            assign stat_off = (masks[g].irq_mask_one == BYTE_ZERO) && (masks[g].irq_mask_two == BYTE_ZERO);
            assign link_off = masks[g].link_ctrl_irq_mask == BYTE_ZERO;
            // An enabled pending request of the first status register
            assign one_hit  = |(req[(g*NUM_REGS+REG_STATUS_ONE)*8 +: 8] & masks[g].irq_mask_one);
            assign link_hit = |(req[(g*NUM_REGS+REG_LINK_STATUS)*8 +: 8] & masks[g].link_ctrl_irq_mask);
            a_status_masked: assert property (@(posedge ref_clk) disable iff (rst)
                stat_off |=> !summary_r[2*g]) else $error("masked status flag raised");
            a_link_masked: assert property (@(posedge ref_clk) disable iff (rst)
                link_off |=> !summary_r[2*g+1]) else $error("masked link flag raised");
            a_status_flag: assert property (@(posedge ref_clk) disable iff (rst)
                one_hit |=> summary_r[2*g]) else $error("status flag missing");
            a_link_flag: assert property (@(posedge ref_clk) disable iff (rst)
                link_hit |=> summary_r[2*g+1]) else $error("link flag missing");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Main scenarios
    c_irq_seen: cover property (@(posedge ref_clk) !int_n);
    c_summary_rd: cover property (@(posedge ref_clk) host_req.rd && summary_hit);
    c_irq_release: cover property (@(posedge ref_clk) !int_n ##1 int_n);
    c_poll_seq: cover property (@(posedge ref_clk) host_req.wr ##2 host_req.rd);
    c_link_flag: cover property (@(posedge ref_clk) summary_r[7]);
endmodule

// ---- rtl/status_bit_cell.sv ----
// One status bit: latch, masked capture and interrupt request
`timescale 1ns/100ps
module status_bit_cell
    import stat_irq_pkg::*;
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // Condition (already synchronised)
    input  wire logic cond,
    input  wire logic is_alarm,
    input  wire logic latching,
    // Host strobes for this register
    input  wire logic mask_wr,
    input  wire logic mask_bit,
    input  wire logic rd_stb,
    // Results
    output logic      read_bit,
    output logic      irq_req
);
    logic cond_d_r;
    logic latch_r;
    logic view_r;
    logic req_r;
    logic rise;
    logic change;
    logic refresh;
    logic bit_read;
    logic req_set;

    assign rise     = cond & ~cond_d_r;
    assign change   = cond ^ cond_d_r;
    assign refresh  = mask_wr & mask_bit;
    assign bit_read = rd_stb & view_r;
    assign read_bit = view_r;
    assign irq_req  = req_r;
    assign req_set  = (is_alarm && change) || (!is_alarm && rise);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cond_d_r <= 1'b0;
            latch_r  <= 1'b0;
            view_r   <= 1'b0;
            req_r    <= 1'b0;
        end else begin
            cond_d_r <= cond;
            // New occurrence wins over a clear in the same cycle
            if (!latching)
                latch_r <= cond;
            else if (rise || (is_alarm && cond))
                latch_r <= 1'b1;
            else if (refresh)
                latch_r <= 1'b0;
            if (refresh)
                view_r <= latch_r | rise;
            // Alarms request on both edges, events on occurrence
            if (req_set)
                req_r <= 1'b1;
            else if (bit_read)
                req_r <= 1'b0;
        end
    end

    a_latch_holds: assert property (@(posedge ref_clk) disable iff (rst)
        latching && latch_r && !refresh |=> latch_r) else $error("latched bit lost without a clear");
    a_alarm_persists: assert property (@(posedge ref_clk) disable iff (rst)
        latching && is_alarm && cond |=> latch_r) else $error("present alarm not kept set");
    a_view_held: assert property (@(posedge ref_clk) disable iff (rst)
        !refresh |=> $stable(view_r)) else $error("view changed without a mask one");
    a_read_releases: assert property (@(posedge ref_clk) disable iff (rst)
        bit_read && !req_set |=> !req_r) else $error("request kept after its bit was read");
endmodule

// ---- testbench/host_model.sv ----
// Host processor model on the parallel port
`timescale 1ns/100ps
module host_model
    import stat_irq_pkg::*;
(
    // Port
    input  wire logic       ref_clk,
    output host_req_t       host_req,
    output logic [7:0]      host_addr,
    input  wire logic [7:0] host_rdata
);
    initial begin
        host_req  = '0;
        host_addr = 8'h00;
    end

    task automatic acc(input logic w, input logic [1:0] f, input logic [3:0] r, input logic [7:0] a,
                       input logic [7:0] d);
        @(negedge ref_clk);
        host_req  = '{w, !w, f, r, d};
        host_addr = a;
        @(negedge ref_clk);
        host_req  = '0;
    endtask

    // Write back the seen bits; an event landing mid-poll on a seen bit is cleared from its latch
    task automatic poll(input logic [1:0] f, input logic [3:0] r, input logic [7:0] m, output logic [7:0] v);
        acc(1'b1, f, r, 8'h00, m);
        acc(1'b0, f, r, 8'h00, 8'h00);
        @(negedge ref_clk);
        v = host_rdata;
        acc(1'b1, f, r, 8'h00, v & m);
    endtask

    task automatic rd_sum(input logic [7:0] a, output logic [7:0] v);
        acc(1'b0, 2'd0, 4'h0, a, 8'h00);
        @(negedge ref_clk);
        v = host_rdata;
    endtask
endmodule

// ---- testbench/stat_irq_ctrl_tb.sv ----
// Self-checking bench for the latched status and interrupt logic
`timescale 1ns/100ps
module stat_irq_ctrl_tb
    import stat_irq_pkg::*;
;
    logic                              ref_clk;
    logic                              rst;
    host_req_t                         host_req;
    logic [7:0]                        host_addr;
    logic [7:0]                        host_rdata;
    irq_masks_t [NUM_FRAMERS-1:0]      masks;
    logic [NUM_FRAMERS*NUM_REGS*8-1:0] status_in;
    logic                              int_n;
    logic [7:0]                        v;
    int                                failures = 0;
    int                                tests_run = 0;
    int                                cycles = 0;

    stat_irq_ctrl u_dut (.ref_clk(ref_clk), .rst(rst), .host_req(host_req), .host_addr(host_addr),
        .host_rdata(host_rdata), .masks(masks), .status_in(status_in), .int_n(int_n));
    host_model u_host (.ref_clk(ref_clk), .host_req(host_req), .host_addr(host_addr), .host_rdata(host_rdata));

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        tests_run++;
        if (s !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask

    // Six cycles covers the two-stage synchroniser plus the interrupt register
    task automatic cond(input int f, input int r, input int b, input logic l);
        @(negedge ref_clk);
        status_in[(f*NUM_REGS+r)*8+b] = l;
        repeat (6) @(negedge ref_clk);
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_event;
        cond(0, 1, 0, 1'b1);
        cond(0, 1, 0, 1'b0);
        chk("int_n", 8'h00, {7'h00, int_n});
        u_host.rd_sum(8'ha0, v);
        chk("summary", 8'h01, v);
        u_host.poll(2'd0, 4'h1, 8'h01, v);
        chk("event bit", 8'h01, v & 8'h01);
        chk("int_n", 8'h01, {7'h00, int_n});
        u_host.poll(2'd0, 4'h1, 8'h01, v);
        chk("event bit", 8'h00, v & 8'h01);
        cond(1, 1, 1, 1'b1);
        cond(1, 1, 1, 1'b0);
        u_host.poll(2'd1, 4'h1, 8'h00, v);
        chk("held bit", 8'h00, v & 8'h02);
        u_host.poll(2'd1, 4'h1, 8'h02, v);
        chk("fresh bit", 8'h02, v & 8'h02);
        $display("test event done");
    endtask

    task automatic t_alarm;
        cond(2, 0, 0, 1'b1);
        chk("int_n", 8'h00, {7'h00, int_n});
        u_host.rd_sum(8'hc3, v);
        chk("summary", 8'h10, v);
        u_host.poll(2'd2, 4'h0, 8'h01, v);
        chk("int_n", 8'h01, {7'h00, int_n});
        u_host.poll(2'd2, 4'h0, 8'h01, v);
        chk("alarm bit", 8'h01, v & 8'h01);
        cond(2, 0, 0, 1'b0);
        chk("int_n", 8'h00, {7'h00, int_n});
        u_host.poll(2'd2, 4'h0, 8'h01, v);
        chk("int_n", 8'h01, {7'h00, int_n});
        $display("test alarm done");
    endtask

    task automatic t_link;
        masks[3].link_ctrl_irq_mask = 8'h00;
        cond(3, 5, 0, 1'b1);
        chk("int_n", 8'h01, {7'h00, int_n});
        masks[3].link_ctrl_irq_mask = 8'hff;
        repeat (3) @(negedge ref_clk);
        chk("int_n", 8'h00, {7'h00, int_n});
        u_host.rd_sum(8'hff, v);
        chk("summary", 8'h80, v);
        u_host.poll(2'd3, 4'h5, 8'h01, v);
        chk("int_n", 8'h01, {7'h00, int_n});
        cond(3, 5, 0, 1'b0);
        chk("int_n", 8'h01, {7'h00, int_n});
        $display("test link done");
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            report_and_stop();
        end
    end

    initial begin
        rst       = 1'b1;
        masks     = '1;
        status_in = '0;
        repeat (12) @(negedge ref_clk);
        rst = 1'b0;
        t_event();
        t_alarm();
        t_link();
        report_and_stop();
    end
endmodule
